// >>> logic/sas_status_bank.sv
// sync detect and alarm status registers with interrupt
// assumes event inputs are one-cycle pulses on clk_i, link clocks come from pins
import sas_pkg::*;

// Behaviour
// [RQ1] bank strobe sets its marker seen flag
// [RQ2] marker alignment rising edge clears marker flags
// [RQ3] sysref event sets sysref seen flag
// [RQ4] sysref_align_enable rising edge clears sysref flag
// [RQ5] write one clears flag, later events reset
// [RQ6] fifo alarms only on input data change
// [RQ7] enabled fifo almost empty sets low alarm
// [RQ8] enabled fifo almost full sets high alarm
// [RQ9] used bank without clock sets loss alarm
// [RQ10] detect loss at half edges missed
// [RQ11] misplaced strobe sets bank misplaced alarm
// [RQ12] unlocked misplaced strobe realigns bank fifo input
// [RQ13] trigger divider realign sets alarm bit 2
// [RQ14] sysref period multiple of trigger period
// [RQ15] misaligned sysref without enable sets bit 1
// [RQ16] sysref or strobe realign sets bit 0
// [RQ17] alarm holds until one written there
// [RQ18] zero write keeps; event beats clear
module sas_status_bank
  import sas_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DATA_W-1:0]    wr_data_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  input  wire logic [NUM_BANKS-1:0] marker_strobe_i,
  input  wire logic [NUM_BANKS-1:0] marker_misplaced_i,
  input  wire logic [NUM_BANKS-1:0] data_change_i,
  input  wire logic [NUM_BANKS-1:0] buffer_almost_empty_i,
  input  wire logic [NUM_BANKS-1:0] buffer_almost_full_i,
  input  wire logic [NUM_BANKS-1:0] bank_clk_i,
  input  wire logic                 sysref_event_i,
  input  wire logic                 sysref_wrong_align_i,
  input  wire logic                 trigger_divider_realign_i,
  output logic [DATA_W-1:0]         rd_data_o,
  output logic                      irq_o,
  output logic [NUM_BANKS-1:0]      fifo_realign_o,
  output logic                      clocks_realign_o
);

  typedef struct packed {
    logic [DATA_W-1:0]              sync_detect_flags;
    logic [DATA_W-1:0]              fifo_level_alarms;
    logic [DATA_W-1:0]              link_clock_strobe_alarms;
    logic [DATA_W-1:0]              system_alignment_alarms;
    logic [CTRL_W-1:0]              ctrl;
    logic [CTRL_W-1:0]              ctrl_prev;
    logic [DATA_W-1:0]              bank_config;
    logic [3:0][DATA_W-1:0]         irq_mask;
    logic [DATA_W-1:0]              rd_data;
    logic                           irq;
    logic [NUM_BANKS-1:0]           fifo_realign;
    logic                           clocks_realign;
  } sas_state_type;

  sas_state_type st_q;
  sas_state_type st_d;

  logic [NUM_BANKS-1:0] low_set;
  logic [NUM_BANKS-1:0] high_set;
  logic [NUM_BANKS-1:0] loss_set;
  logic [NUM_BANKS-1:0] realign_req;

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      // held data never moves the fifo level, so only transitions count
      assign low_set[b]  = st_q.bank_config[FIFO_EN_LSB+b] & data_change_i[b]
                         & buffer_almost_empty_i[b]; // RQ6 RQ7
      assign high_set[b] = st_q.bank_config[FIFO_EN_LSB+b] & data_change_i[b]
                         & buffer_almost_full_i[b]; // RQ6 RQ8
      assign realign_req[b] = marker_misplaced_i[b] & ~st_q.ctrl[CTRL_LOCK]; // RQ12

      sas_clk_loss u_loss (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .link_clk_i (bank_clk_i[b]),
        .active_i   (st_q.bank_config[BANK_USE_LSB+b]),
        .loss_o     (loss_set[b])
      ); // RQ9
    end
  endgenerate

  logic marker_align_rise;
  logic sysref_align_rise;
  logic realign_any;
  logic misalign_set;

  assign marker_align_rise = st_q.ctrl[CTRL_MARKER_AL] & ~st_q.ctrl_prev[CTRL_MARKER_AL];
  assign sysref_align_rise = st_q.ctrl[CTRL_SYSREF_AL] & ~st_q.ctrl_prev[CTRL_SYSREF_AL];
  assign misalign_set = sysref_wrong_align_i & ~st_q.ctrl[CTRL_SYSREF_AL]; // RQ15
  // a misaligned sysref realigns only when alignment is enabled
  assign realign_any = (|realign_req)
                     | (sysref_wrong_align_i & st_q.ctrl[CTRL_SYSREF_AL]); // RQ16

  always_comb begin
    st_d = st_q;
    st_d.rd_data        = '0;
    st_d.fifo_realign   = realign_req; // RQ12
    st_d.clocks_realign = realign_any;
    st_d.ctrl_prev      = st_q.ctrl;

    // software writes; clears first so that same-cycle events win
    if (wr_i) begin
      unique case (addr_i)
        OFS_SYNC_DETECT: begin
          st_d.sync_detect_flags = ((st_q.sync_detect_flags & ~wr_data_i) & SYNC_W1C_MASK)
                                 | (wr_data_i & SYNC_RSVD_MASK); // RQ5 RQ18
        end
        OFS_FIFO_LEVEL: begin
          st_d.fifo_level_alarms = st_q.fifo_level_alarms & ~wr_data_i; // RQ17
        end
        OFS_LINK_STROBE: begin
          st_d.link_clock_strobe_alarms = st_q.link_clock_strobe_alarms & ~wr_data_i; // RQ17
        end
        OFS_SYSTEM_ALIGN: begin
          st_d.system_alignment_alarms = ((st_q.system_alignment_alarms & ~wr_data_i)
                                       & SYS_W1C_MASK) | (wr_data_i & SYS_RSVD_MASK); // RQ17
        end
        OFS_ALIGN_CTRL: begin
          st_d.ctrl = wr_data_i[CTRL_W-1:0];
        end
        OFS_BANK_CONFIG: begin
          st_d.bank_config = wr_data_i;
        end
        OFS_IRQ_MASK_SYNC: begin
          st_d.irq_mask[0] = wr_data_i;
        end
        OFS_IRQ_MASK_FIFO: begin
          st_d.irq_mask[1] = wr_data_i;
        end
        OFS_IRQ_MASK_LINK: begin
          st_d.irq_mask[2] = wr_data_i;
        end
        OFS_IRQ_MASK_SYS: begin
          st_d.irq_mask[3] = wr_data_i;
        end
        default: begin
        end
      endcase
    end

    // alignment bits clear the detect flags on their rising edge
    if (marker_align_rise) begin
      st_d.sync_detect_flags[MARKER_LSB +: NUM_BANKS] = '0; // RQ2
    end
    if (sysref_align_rise) begin
      st_d.sync_detect_flags[SYSREF_BIT] = 1'b0; // RQ4
    end

    // hardware sets last: an event beats a clear in the same cycle
    st_d.sync_detect_flags[MARKER_LSB +: NUM_BANKS] =
      st_d.sync_detect_flags[MARKER_LSB +: NUM_BANKS] | marker_strobe_i; // RQ1 RQ18
    st_d.sync_detect_flags[SYSREF_BIT] =
      st_d.sync_detect_flags[SYSREF_BIT] | sysref_event_i; // RQ3 RQ18
    st_d.fifo_level_alarms[LOW_LSB +: NUM_BANKS] =
      st_d.fifo_level_alarms[LOW_LSB +: NUM_BANKS] | low_set; // RQ7
    st_d.fifo_level_alarms[HIGH_LSB +: NUM_BANKS] =
      st_d.fifo_level_alarms[HIGH_LSB +: NUM_BANKS] | high_set; // RQ8
    st_d.link_clock_strobe_alarms[CLKLOSS_LSB +: NUM_BANKS] =
      st_d.link_clock_strobe_alarms[CLKLOSS_LSB +: NUM_BANKS] | loss_set; // RQ9
    st_d.link_clock_strobe_alarms[MISPLACED_LSB +: NUM_BANKS] =
      st_d.link_clock_strobe_alarms[MISPLACED_LSB +: NUM_BANKS] | marker_misplaced_i; // RQ11
    st_d.system_alignment_alarms[TRIG_BIT] =
      st_d.system_alignment_alarms[TRIG_BIT] | trigger_divider_realign_i; // RQ13
    st_d.system_alignment_alarms[MISALIGN_BIT] =
      st_d.system_alignment_alarms[MISALIGN_BIT] | misalign_set; // RQ15
    st_d.system_alignment_alarms[REALIGN_BIT] =
      st_d.system_alignment_alarms[REALIGN_BIT] | realign_any; // RQ16

    // mask bit high lets the status bit through
    // irq_mask[3] is the top byte, so the system alarms lead the concatenation
    st_d.irq = |({st_d.system_alignment_alarms & SYS_W1C_MASK,
                  st_d.link_clock_strobe_alarms,
                  st_d.fifo_level_alarms,
                  st_d.sync_detect_flags & SYNC_W1C_MASK} & st_d.irq_mask);

    // read data shows the pre-write value, in the next cycle only
    if (rd_i) begin
      unique case (addr_i)
        OFS_SYNC_DETECT:   st_d.rd_data = st_q.sync_detect_flags;
        OFS_FIFO_LEVEL:    st_d.rd_data = st_q.fifo_level_alarms;
        OFS_LINK_STROBE:   st_d.rd_data = st_q.link_clock_strobe_alarms;
        OFS_SYSTEM_ALIGN:  st_d.rd_data = st_q.system_alignment_alarms;
        OFS_ALIGN_CTRL:    st_d.rd_data = {{(DATA_W-CTRL_W){1'b0}}, st_q.ctrl};
        OFS_BANK_CONFIG:   st_d.rd_data = st_q.bank_config;
        OFS_IRQ_MASK_SYNC: st_d.rd_data = st_q.irq_mask[0];
        OFS_IRQ_MASK_FIFO: st_d.rd_data = st_q.irq_mask[1];
        OFS_IRQ_MASK_LINK: st_d.rd_data = st_q.irq_mask[2];
        OFS_IRQ_MASK_SYS:  st_d.rd_data = st_q.irq_mask[3];
        default:           st_d.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data_o        = st_q.rd_data;
  assign irq_o            = st_q.irq;
  assign fifo_realign_o   = st_q.fifo_realign;
  assign clocks_realign_o = st_q.clocks_realign;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic wr_sync_clear;
  assign wr_sync_clear = wr_i && (addr_i == OFS_SYNC_DETECT);

  a_marker_sets: assert property ( // RQ1
    (|marker_strobe_i) |=>
      ((st_q.sync_detect_flags[MARKER_LSB +: NUM_BANKS] & $past(marker_strobe_i))
       == $past(marker_strobe_i)))
    else $error("marker flag not set by strobe");

  a_marker_align_clear: assert property ( // RQ2
    (wr_i && addr_i == OFS_ALIGN_CTRL && wr_data_i[CTRL_MARKER_AL]
     && !st_q.ctrl[CTRL_MARKER_AL]) ##1 (marker_strobe_i == '0) |=>
      (st_q.sync_detect_flags[MARKER_LSB +: NUM_BANKS] == '0))
    else $error("marker flags survive alignment rise");

  a_sysref_sets: assert property ( // RQ3
    sysref_event_i |=> st_q.sync_detect_flags[SYSREF_BIT])
    else $error("sysref flag not set");

  a_sysref_align_clear: assert property ( // RQ4
    (wr_i && addr_i == OFS_ALIGN_CTRL && wr_data_i[CTRL_SYSREF_AL]
     && !st_q.ctrl[CTRL_SYSREF_AL]) ##1 !sysref_event_i |=>
      !st_q.sync_detect_flags[SYSREF_BIT])
    else $error("sysref flag survives enable rise");

  a_w1c_sysref: assert property ( // RQ5
    (wr_sync_clear && wr_data_i[SYSREF_BIT] && !sysref_event_i && !sysref_align_rise)
      |=> !st_q.sync_detect_flags[SYSREF_BIT])
    else $error("write one did not clear sysref flag");

  a_fifo_quiet: assert property ( // RQ6
    (data_change_i == '0) |=>
      ((st_q.fifo_level_alarms & ~$past(st_q.fifo_level_alarms)) == '0))
    else $error("fifo alarm without data change");

  a_low_gated: assert property ( // RQ7
    ##1 ((st_q.fifo_level_alarms[LOW_LSB +: NUM_BANKS]
          & ~$past(st_q.fifo_level_alarms[LOW_LSB +: NUM_BANKS])
          & ~$past(st_q.bank_config[FIFO_EN_LSB +: NUM_BANKS])) == '0))
    else $error("disabled fifo raised low alarm");

  a_high_gated: assert property ( // RQ8
    ##1 ((st_q.fifo_level_alarms[HIGH_LSB +: NUM_BANKS]
          & ~$past(st_q.fifo_level_alarms[HIGH_LSB +: NUM_BANKS])
          & ~$past(st_q.bank_config[FIFO_EN_LSB +: NUM_BANKS])) == '0))
    else $error("disabled fifo raised high alarm");

  a_misplaced_sets: assert property ( // RQ11
    (|marker_misplaced_i) |=>
      ((st_q.link_clock_strobe_alarms[MISPLACED_LSB +: NUM_BANKS]
        & $past(marker_misplaced_i)) == $past(marker_misplaced_i)))
    else $error("misplaced alarm not set");

  a_lock_realign: assert property ( // RQ12
    ##1 (fifo_realign_o == ($past(marker_misplaced_i) & ~{NUM_BANKS{$past(st_q.ctrl[CTRL_LOCK])}})))
    else $error("fifo realign disagrees with lock");

  a_misalign_sets: assert property ( // RQ15
    (sysref_wrong_align_i && !st_q.ctrl[CTRL_SYSREF_AL]) |=>
      st_q.system_alignment_alarms[MISALIGN_BIT] && !clocks_realign_o)
    else $error("misalign alarm not set");

  a_event_beats_clear: assert property ( // RQ18
    (wr_i && addr_i == OFS_SYSTEM_ALIGN && wr_data_i[TRIG_BIT] && trigger_divider_realign_i)
      |=> st_q.system_alignment_alarms[TRIG_BIT] [*2])
    else $error("clear beat a coincident event");

  a_zero_write_keeps: assert property ( // RQ17
    (wr_i && addr_i == OFS_FIFO_LEVEL && wr_data_i == '0) |=>
      ((st_q.fifo_level_alarms & $past(st_q.fifo_level_alarms))
       == $past(st_q.fifo_level_alarms)))
    else $error("zero write changed fifo alarms");

endmodule

// >>> inc/sas_pkg.sv
// sync detect and alarm status bank: shared offsets, fields and timing
// assumes one 25 MHz clock; event inputs already on that clock
package sas_pkg;

  localparam int NUM_BANKS = 4;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int CTRL_W    = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_SYNC_DETECT   = 12'h800;
  localparam logic [ADDR_W-1:0] OFS_FIFO_LEVEL    = 12'h820;
  localparam logic [ADDR_W-1:0] OFS_LINK_STROBE   = 12'h821;
  localparam logic [ADDR_W-1:0] OFS_SYSTEM_ALIGN  = 12'h822;
  localparam logic [ADDR_W-1:0] OFS_ALIGN_CTRL    = 12'h830;
  localparam logic [ADDR_W-1:0] OFS_BANK_CONFIG   = 12'h831;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_SYNC = 12'h840;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_FIFO = 12'h841;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_LINK = 12'h842;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_SYS  = 12'h843;

  // field positions
  localparam int MARKER_LSB     = 4;  // sync_detect_flags[7:4]
  localparam int SYSREF_BIT     = 0;
  localparam int LOW_LSB        = 4;  // fifo_level_alarms[7:4]
  localparam int HIGH_LSB       = 0;  // fifo_level_alarms[3:0]
  localparam int CLKLOSS_LSB    = 4;  // link_clock_strobe_alarms[7:4]
  localparam int MISPLACED_LSB  = 0;  // link_clock_strobe_alarms[3:0]
  localparam int TRIG_BIT       = 2;
  localparam int MISALIGN_BIT   = 1;
  localparam int REALIGN_BIT    = 0;
  localparam int CTRL_MARKER_AL = 0;  // marker alignment control
  localparam int CTRL_SYSREF_AL = 1;  // sysref_align_enable
  localparam int CTRL_LOCK      = 2;  // marker_position_lock
  localparam int BANK_USE_LSB   = 4;  // bank configured for use
  localparam int FIFO_EN_LSB    = 0;  // bank fifo enabled

  // plain read/write reserved bits and write-one-to-clear bits
  localparam logic [DATA_W-1:0] SYNC_RSVD_MASK = 8'h0e;
  localparam logic [DATA_W-1:0] SYNC_W1C_MASK  = 8'hf1;
  localparam logic [DATA_W-1:0] SYS_RSVD_MASK  = 8'hf8;
  localparam logic [DATA_W-1:0] SYS_W1C_MASK   = 8'h07;
  localparam logic [DATA_W-1:0] REG_RESET      = 8'h00;

  // clock-loss window: eight link periods, half of their edges
  localparam int CLK_PERIOD_NS  = 40;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LOSS_PERIODS   = 8;
  localparam int LOSS_WIN_CYC   = (LOSS_PERIODS * LINK_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;
  localparam logic [CNT_W-1:0] LOSS_WIN_LAST  = CNT_W'(LOSS_WIN_CYC - 1);
  localparam logic [CNT_W-1:0] LOSS_MAX_EDGES = CNT_W'(LOSS_PERIODS);

endpackage

// >>> logic/sas_clk_loss.sv
// per-bank link clock activity monitor
// assumes the link clock is much slower than clk_i so its level can be sampled
module sas_clk_loss
  import sas_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic link_clk_i,
  input  wire logic active_i,
  output logic      loss_o
);

  typedef struct packed {
    logic [2:0]       sync;
    logic             level;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] edges;
    logic             loss;
  } sas_loss_state_type;

  sas_loss_state_type st_q;
  sas_loss_state_type st_d;

  always_comb begin
    logic edge_seen;
    edge_seen = 1'b0;
    st_d = st_q;
    st_d.loss = 1'b0;
    st_d.sync = {st_q.sync[1:0], link_clk_i};
    // a change counts once the second and third stage agree
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.level = st_q.sync[1];
    end
    edge_seen = (st_d.level != st_q.level);
    if (!active_i) begin
      st_d.cnt   = '0;
      st_d.edges = '0;
    end else if (st_q.cnt == LOSS_WIN_LAST) begin
      // half or fewer of the expected edges seen in the window
      st_d.loss  = (st_q.edges + CNT_W'(edge_seen)) <= LOSS_MAX_EDGES; // RQ10
      st_d.cnt   = '0;
      st_d.edges = '0;
    end else begin
      st_d.cnt   = st_q.cnt + 1'b1;
      st_d.edges = st_q.edges + CNT_W'(edge_seen);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign loss_o = st_q.loss;

endmodule

// >>> bench/sas_fpga_model.sv
// far-side source model: per-bank link clocks and a periodic sysref
// assumes clk_i is the core clock; link period comes from sas_pkg
module sas_fpga_model
  import sas_pkg::*;
#(
  parameter int TRIG_CYC = 4,
  parameter int SR_MULT  = 6
)
(
  input  wire logic                 clk_i,
  input  wire logic                 run_i,
  input  wire logic [NUM_BANKS-1:0] stop_i,
  input  wire logic [NUM_BANKS-1:0] half_i,
  output logic      [NUM_BANKS-1:0] bank_clk_o,
  output logic                      sysref_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;
  int tick = 0;
  int slot = 0;
  int sr_cnt = 0;
  initial begin
    bank_clk_o = '0;
    sysref_o = 1'b0;
  end
  always @(posedge clk_i) begin
    // period kept a whole number of trigger periods
    sysref_o <= run_i && (sr_cnt == 0);
    if (run_i) begin
      tick <= (tick == HALF_CYC - 1) ? 0 : tick + 1;
      sr_cnt <= (sr_cnt == TRIG_CYC * SR_MULT - 1) ? 0 : sr_cnt + 1;
      if (tick == HALF_CYC - 1) begin
        slot <= slot + 1;
        // half mode drops two of every four edges
        for (int i = 0; i < NUM_BANKS; i++) begin
          if (!stop_i[i] && !(half_i[i] && slot[1])) bank_clk_o[i] <= ~bank_clk_o[i];
        end
      end
    end
  end
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the sync detect and alarm status bank
// assumes sas_pkg offsets; link clocks come from sas_fpga_model, sysref from it or from the bench rows
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sas_pkg::*;
  typedef struct {
    logic [22:0]       ev;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] x;
  } sas_row_type;
  logic                 clk, nrst, wr, rd, sr_tb, sr_m, tr, wa, irq, clk_re, run;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdat, rdata;
  logic [NUM_BANKS-1:0] mk, mis, dc, ae, af, bclk, stop, half, frl;
  logic [4:0]           seen;
  logic                 seen_clr;
  int                   miscompares = 0;
  int                   check_count = 0;
  logic [ADDR_W-1:0]    regs [4] = '{OFS_SYNC_DETECT, OFS_FIFO_LEVEL, OFS_LINK_STROBE,
                                     OFS_SYSTEM_ALIGN};
  logic [DATA_W-1:0]    w1c [4] = '{SYNC_W1C_MASK, 8'hff, 8'hff, SYS_W1C_MASK};
  // ev = {data change, strobe, misplaced, almost empty, almost full, sysref, trig, wrong}
  sas_row_type          rows [10] = '{
    '{23'h008000, OFS_SYNC_DETECT, 8'h10}, '{23'h040000, OFS_SYNC_DETECT, 8'h80},
    '{23'h000004, OFS_SYNC_DETECT, 8'h01}, '{23'h001000, OFS_LINK_STROBE, 8'h02},
    '{23'h200200, OFS_FIFO_LEVEL, 8'h40},  '{23'h400040, OFS_FIFO_LEVEL, 8'h08},
    '{23'h000200, OFS_FIFO_LEVEL, 8'h00},  '{23'h000002, OFS_SYSTEM_ALIGN, 8'h04},
    '{23'h000001, OFS_SYSTEM_ALIGN, 8'h02}, '{23'h000800, OFS_SYSTEM_ALIGN, 8'h01}};

  sas_status_bank uut (.clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wr_data_i(wdat),
    .wr_i(wr), .rd_i(rd), .marker_strobe_i(mk), .marker_misplaced_i(mis),
    .data_change_i(dc), .buffer_almost_empty_i(ae), .buffer_almost_full_i(af),
    .bank_clk_i(bclk), .sysref_event_i(sr_tb | sr_m), .sysref_wrong_align_i(wa),
    .trigger_divider_realign_i(tr), .rd_data_o(rdata), .irq_o(irq),
    .fifo_realign_o(frl), .clocks_realign_o(clk_re));
  sas_fpga_model fpga (.clk_i(clk), .run_i(run), .stop_i(stop), .half_i(half),
    .bank_clk_o(bclk), .sysref_o(sr_m));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) seen <= seen_clr ? 5'h00 : (seen | {clk_re, frl});

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic drv(input logic [22:0] ev, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d, input logic w);
    @(posedge clk);
    {dc, mk, mis, ae, af, sr_tb, tr, wa} <= ev;
    addr <= a;
    wdat <= d;
    wr <= w;
    @(posedge clk);
    {dc, mk, mis, ae, af, sr_tb, tr, wa} <= '0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, x);
  endtask
  task automatic clear_all();
    foreach (regs[k]) drv('0, regs[k], w1c[k], 1'b1);
  endtask
  task automatic irqc(input logic [7:0] x);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, irq}, x);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    {dc, mk, mis, ae, af, sr_tb, tr, wa, wr, rd, run} = '0;
    addr = '0;
    wdat = '0;
    stop = '0;
    half = '0;
    seen_clr = 1'b1;
    nrst = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    seen_clr <= 1'b0;
    foreach (regs[k]) rdc(regs[k], REG_RESET);
    rdc(12'h123, 8'h00);
    drv('0, OFS_BANK_CONFIG, 8'h0f, 1'b1);
    foreach (rows[k]) begin
      clear_all();
      drv(rows[k].ev, '0, 8'h00, 1'b0);
      rdc(rows[k].a, rows[k].x);
      drv('0, rows[k].a, rows[k].x, 1'b1);
      rdc(rows[k].a, 8'h00);
    end
    chk({3'h0, seen}, 8'h13);
    // lock set: misplaced strobe must not realign
    clear_all();
    drv('0, OFS_ALIGN_CTRL, 8'h04, 1'b1);
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
    drv(23'h002000, '0, 8'h00, 1'b0);
    rdc(OFS_LINK_STROBE, 8'h04);
    rdc(OFS_SYSTEM_ALIGN, 8'h00);
    chk({3'h0, seen}, 8'h00);
    drv(23'h078004, '0, 8'h00, 1'b0);
    rdc(OFS_SYNC_DETECT, 8'hf1);
    drv('0, OFS_ALIGN_CTRL, 8'h03, 1'b1);
    rdc(OFS_SYNC_DETECT, 8'h00);
    clear_all();
    drv(23'h000001, '0, 8'h00, 1'b0);
    rdc(OFS_SYSTEM_ALIGN, 8'h01);
    // event and clearing write in the same cycle
    drv(23'h000004, OFS_SYNC_DETECT, 8'h01, 1'b1);
    rdc(OFS_SYNC_DETECT, 8'h01);
    drv(23'h018000, '0, 8'h00, 1'b0);
    drv('0, OFS_SYNC_DETECT, 8'h1e, 1'b1);
    rdc(OFS_SYNC_DETECT, 8'h2f);
    clear_all();
    drv(23'h000004, '0, 8'h00, 1'b0);
    irqc(8'h00);
    drv('0, OFS_IRQ_MASK_SYNC, 8'h01, 1'b1);
    irqc(8'h01);
    drv('0, OFS_SYNC_DETECT, 8'h01, 1'b1);
    irqc(8'h00);
    // system alarm through its own mask; event beats a coincident clear
    drv('0, OFS_IRQ_MASK_SYS, 8'h04, 1'b1);
    drv(23'h000002, OFS_SYSTEM_ALIGN, 8'h04, 1'b1);
    rdc(OFS_SYSTEM_ALIGN, 8'h04);
    irqc(8'h01);
    drv('0, OFS_SYSTEM_ALIGN, 8'h04, 1'b1);
    irqc(8'h00);
    // bank1 stopped, bank2 half rate, bank3 stopped but unused
    @(posedge clk);
    stop <= 4'ha;
    half <= 4'h4;
    run <= 1'b1;
    drv('0, OFS_BANK_CONFIG, 8'h7f, 1'b1);
    repeat (250) @(posedge clk);
    rdc(OFS_LINK_STROBE, 8'h60);
    rdc(OFS_SYNC_DETECT, 8'h01);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(OFS_LINK_STROBE, 8'h00);
    complete_run();
  end
endmodule
